// ---- dsa_addr_gen.sv ----
// data space paging, software stack and program space addressing
// assumes the core holds no request while busy_o is high and reads
// stack and data words from memory on the cycle after mem_req_o,
// and never raises call and exception in one cycle
//
// Behaviour
// - lower base half reaches memory unpaged
// - page register resets to one
// - paged access with page zero traps
// - writing zero to page register ignored
// - ea bit 15 selects paged window
// - stack pointer auto-updated, also software writable
// - stack pointer bit zero always zero
// - every reset loads stack pointer start
// - push write then increment, pop decrement
// - pc low word first, upper next
// - call zero-fills upper saved byte
// - exception saves status low byte too
// - stack and active frame pointer unpaged
// - 24-bit program, 16-bit data words
// - fetch address from pc, ends zero
// - table ops reach any byte or word
// - program window read-only, low word only
// - table ops unaligned, reads reach configuration
`timescale 1ns/1ns
`default_nettype none

module dsa_addr_gen (
  // clock and reset
  input  wire logic                    clk_sys_i,
  input  wire logic                    resetn_i,
  // page register write
  input  wire logic                    page_wr_i,
  input  wire logic [9:0]              page_wdata_i,
  // table page register write
  input  wire logic                    tpage_wr_i,
  input  wire logic [7:0]              tpage_wdata_i,
  // stack pointer word write
  input  wire logic                    sp_wr_i,
  input  wire logic [15:0]             sp_wdata_i,
  // core state
  input  wire logic [22:0]             pc_i,
  input  wire logic [15:0]             cpu_status_reg_i,
  input  wire logic                    frame_active_flag_i,
  // stack and data requests
  input  wire dsa_pkg::dsa_stk_req_t   stk_req_i,
  input  wire dsa_pkg::dsa_dacc_t      dacc_i,
  // table requests
  input  wire logic                    tbl_valid_i,
  input  wire logic                    tbl_write_i,
  input  wire logic                    tbl_byte_i,
  input  wire logic [15:0]             tbl_ea_i,
  // handshake
  output logic                         busy_o,
  output logic                         dacc_ready_o,
  // memory side
  output dsa_pkg::dsa_mem_req_t        mem_req_o,
  output dsa_pkg::dsa_tbl_req_t        tbl_req_o,
  output logic [23:0]                  fetch_addr_o,
  output logic                         addr_error_o,
  // register views
  output logic [15:0]                  stack_pointer_word_o,
  output logic [9:0]                   data_read_page_reg_o,
  output logic [7:0]                   table_page_reg_o
);

  // ==========================================================================
  // declarations
  // sequencer and request registers
  dsa_pkg::dsa_stk_st_t  st_q;
  dsa_pkg::dsa_stk_st_t  st_d;
  dsa_pkg::dsa_mem_req_t mem_q;
  dsa_pkg::dsa_mem_req_t mem_d;
  dsa_pkg::dsa_tbl_req_t tbl_q;
  dsa_pkg::dsa_tbl_req_t tbl_d;

  // pointer and side registers
  logic [15:0] sp_q;
  logic [15:0] sp_d;
  logic [15:0] hi_q;
  logic [15:0] hi_d;
  logic [7:0]  tpage_q;
  logic [7:0]  tpage_d;
  logic [23:0] fetch_q;
  logic [23:0] fetch_d;
  logic        err_q;
  logic        err_d;

  // page register view
  logic [9:0]  page;
  logic        page_zero;
  logic        page_prog;

  // request decode
  logic        idle;
  logic        do_sp_wr;
  logic        do_pc_push;
  logic        do_push;
  logic        do_ret;
  logic        do_pop;
  logic        do_dacc;

  // stack arithmetic
  logic [15:0] sp_inc;
  logic [15:0] sp_dec;
  logic [15:0] hi_word;

  // data access decode
  logic        dacc_unpaged;
  logic        dacc_upper;
  logic        dacc_paged;
  logic        dacc_trap;
  logic        win_write;
  logic        win_read;

  // address paths
  logic [24:0] dacc_addr;
  logic [24:0] sp_addr;
  logic [24:0] spdec_addr;
  logic [24:0] prog_win_addr;

  // ==========================================================================
  // page register
  dsa_page_reg u_page (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .wr_i      (page_wr_i),
    .wdata_i   (page_wdata_i),
    .page_o    (page),
    .zero_o    (page_zero),
    .prog_o    (page_prog)
  );

  // ==========================================================================
  // request decode
  // software write of the pointer wins, then pc pushes, data pushes,
  // returns, pops and last plain data accesses
  assign idle       = (st_q == dsa_pkg::ST_IDLE);
  assign do_sp_wr   = idle && sp_wr_i;
  assign do_pc_push = idle && !sp_wr_i && (stk_req_i.call || stk_req_i.exc);
  assign do_push    = idle && !sp_wr_i && !do_pc_push && stk_req_i.push;
  assign do_ret     = idle && !sp_wr_i && !do_pc_push && !do_push && stk_req_i.ret;
  assign do_pop     = idle && !sp_wr_i && !do_pc_push && !do_push && !do_ret
                      && stk_req_i.pop;
  assign dacc_ready_o = idle && !sp_wr_i && !stk_req_i.call && !stk_req_i.exc
                        && !stk_req_i.push && !stk_req_i.ret && !stk_req_i.pop;
  assign do_dacc    = dacc_ready_o && dacc_i.valid;
  // requests while busy are dropped
  assign busy_o     = !idle;

  // ==========================================================================
  // stack pointer arithmetic
  // one word is two bytes, the stack grows upward
  // no trap on a wrap past the base range
  assign sp_inc = sp_q + dsa_pkg::SP_STEP;
  assign sp_dec = sp_q - dsa_pkg::SP_STEP;

  // second saved word: pc upper bits under status low byte or zero fill
  // an exception wins when call and exception meet
  assign hi_word = stk_req_i.exc
                 ? {cpu_status_reg_i[7:0], dsa_pkg::PC_PAD, pc_i[22:16]}
                 : {dsa_pkg::CALL_HI_FILL, dsa_pkg::PC_PAD, pc_i[22:16]};

  // stack addresses never see the page register
  assign sp_addr    = {dsa_pkg::BASE_PAGE, sp_q};
  assign spdec_addr = {dsa_pkg::BASE_PAGE, sp_dec};

  // ==========================================================================
  // data access address generation
  // stack pointer based access, or frame pointer while a frame is active,
  // stays in the 16-bit base range
  assign dacc_unpaged = dacc_i.via_sp || (dacc_i.via_fp && frame_active_flag_i);
  assign dacc_upper   = dacc_i.ea[dsa_pkg::EA_WIN_BIT];
  assign dacc_paged   = dacc_upper && !dacc_unpaged;
  // page zero through the upper window is refused and traps
  assign dacc_trap    = dacc_paged && page_zero;
  // the program window answers reads only
  assign win_write    = dacc_paged && page_prog && dacc_i.write;
  assign win_read     = dacc_paged && page_prog;

  // lower half goes out as page zero whatever the page register holds
  assign dacc_addr = dacc_paged
                   ? {page, dacc_i.ea[14:0]}
                   : {dsa_pkg::BASE_PAGE, dacc_i.ea};

  // program window address: low word of the selected program word
  assign prog_win_addr = {2'h0, page[7:0], dacc_i.ea[14:0]};

  // ==========================================================================
  // sequencer next state and memory request
  always_comb begin
    st_d  = st_q;
    sp_d  = sp_q;
    hi_d  = hi_q;
    err_d = 1'b0;
    mem_d = '0;
    unique case (st_q)
      dsa_pkg::ST_IDLE: begin
        if (do_sp_wr) begin
          sp_d = sp_wdata_i;
        end else if (do_pc_push) begin
          // low pc word into the free slot, upper word follows
          mem_d.valid = 1'b1;
          mem_d.write = 1'b1;
          mem_d.addr  = sp_addr;
          mem_d.wdata = pc_i[15:0];
          hi_d        = hi_word;
          sp_d        = sp_inc;
          st_d        = dsa_pkg::ST_PUSH_HI;
        end else if (do_push) begin
          // write at the free word, then step past it
          mem_d.valid = 1'b1;
          mem_d.write = 1'b1;
          mem_d.addr  = sp_addr;
          mem_d.wdata = stk_req_i.wdata;
          sp_d        = sp_inc;
        end else if (do_ret) begin
          // step back first, upper word comes off first
          mem_d.valid = 1'b1;
          mem_d.addr  = spdec_addr;
          sp_d        = sp_dec;
          st_d        = dsa_pkg::ST_POP_LO;
        end else if (do_pop) begin
          // step back, then read the top word
          mem_d.valid = 1'b1;
          mem_d.addr  = spdec_addr;
          sp_d        = sp_dec;
        end else if (do_dacc) begin
          // a trapped access never reaches memory
          if (dacc_trap) begin
            err_d = 1'b1;
          end else if (!win_write) begin
            // window writes are dropped without a trap
            mem_d.valid = 1'b1;
            mem_d.write = dacc_i.write;
            mem_d.prog  = win_read;
            mem_d.addr  = win_read ? prog_win_addr : dacc_addr;
            mem_d.wdata = dacc_i.wdata;
          end
        end
      end
      dsa_pkg::ST_PUSH_HI: begin
        // second saved word of the pc frame
        mem_d.valid = 1'b1;
        mem_d.write = 1'b1;
        mem_d.addr  = sp_addr;
        mem_d.wdata = hi_q;
        sp_d        = sp_inc;
        st_d        = dsa_pkg::ST_IDLE;
      end
      dsa_pkg::ST_POP_LO: begin
        // low pc word of the frame being returned from
        mem_d.valid = 1'b1;
        mem_d.addr  = spdec_addr;
        sp_d        = sp_dec;
        st_d        = dsa_pkg::ST_IDLE;
      end
      default: begin
        st_d = dsa_pkg::ST_IDLE;
      end
    endcase
    // word alignment of the stack pointer is kept in hardware
    sp_d[dsa_pkg::SP_ALIGN_BIT] = 1'b0;
  end

  // ==========================================================================
  // table operations
  // page register above a 16-bit ea, any byte, no alignment check
  // configuration space writes are not blocked here
  always_comb begin
    tbl_d         = '0;
    tbl_d.valid   = tbl_valid_i;
    tbl_d.write   = tbl_write_i;
    tbl_d.byte_op = tbl_byte_i;
    tbl_d.cfg     = tpage_q[dsa_pkg::TBL_CFG_BIT];
    tbl_d.addr    = {tpage_q, tbl_ea_i};
  end

  // ==========================================================================
  // sequencer and stack pointer registers
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_q <= dsa_pkg::ST_IDLE;
      sp_q <= dsa_pkg::SP_RST;
      hi_q <= '0;
    end else begin
      st_q <= st_d;
      sp_q <= sp_d;
      hi_q <= hi_d;
    end
  end

  // memory request and trap pulse registers
  // the trap pulse stands for one cycle only
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mem_q <= '0;
      err_q <= 1'b0;
    end else begin
      mem_q <= mem_d;
      err_q <= err_d;
    end
  end

  // table page load and fetch address, pc bit 0 unused
  assign tpage_d = tpage_wr_i ? tpage_wdata_i : tpage_q;
  assign fetch_d = {1'b0, pc_i[22:1], 1'b0};

  // table page register and table request
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tpage_q <= dsa_pkg::TPAGE_RST;
      tbl_q   <= '0;
    end else begin
      tpage_q <= tpage_d;
      tbl_q   <= tbl_d;
    end
  end

  // instruction fetch address, 24-bit program word space
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fetch_q <= '0;
    end else begin
      fetch_q <= fetch_d;
    end
  end

  // ==========================================================================
  // outputs
  // register views come straight from flip-flops
  assign mem_req_o            = mem_q;
  assign tbl_req_o            = tbl_q;
  assign fetch_addr_o         = fetch_q;
  assign addr_error_o         = err_q;
  assign stack_pointer_word_o = sp_q;
  assign data_read_page_reg_o = page;
  assign table_page_reg_o     = tpage_q;

endmodule

`default_nettype wire

// ---- dsa_addr_gen_asserts.sv ----
// concurrent checks on the ports of the addressing block
// assumes one core clock and an active low asynchronous reset
`timescale 1ns/1ns
`default_nettype none

module dsa_addr_gen_asserts (
  // clock and reset
  input wire logic                  clk_sys_i,
  input wire logic                  resetn_i,
  // inputs watched
  input wire logic                  page_wr_i,
  input wire logic [9:0]            page_wdata_i,
  input wire logic                  sp_wr_i,
  input wire logic [22:0]           pc_i,
  input wire logic [15:0]           cpu_status_reg_i,
  input wire logic                  frame_active_flag_i,
  input wire dsa_pkg::dsa_stk_req_t stk_req_i,
  input wire dsa_pkg::dsa_dacc_t    dacc_i,
  input wire logic                  tbl_valid_i,
  input wire logic [15:0]           tbl_ea_i,
  // outputs watched
  input wire logic                  busy_o,
  input wire logic                  dacc_ready_o,
  input wire dsa_pkg::dsa_mem_req_t mem_req_o,
  input wire dsa_pkg::dsa_tbl_req_t tbl_req_o,
  input wire logic [23:0]           fetch_addr_o,
  input wire logic [15:0]           stack_pointer_word_o,
  input wire logic [9:0]            data_read_page_reg_o,
  input wire logic [7:0]            table_page_reg_o
);
  // ==========================================================================
  // properties
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  wire logic acc_w = dacc_i.valid && dacc_ready_o;
  wire logic unp_w = dacc_i.via_sp || (dacc_i.via_fp && frame_active_flag_i);
  wire logic stk_w = !busy_o && !sp_wr_i;

  property p_sp_align; stack_pointer_word_o[0] == 1'b0; endproperty
  property p_rst_vals;
    $rose(resetn_i) |-> stack_pointer_word_o == 16'h1000 && data_read_page_reg_o == 10'h001;
  endproperty
  property p_page_keep; page_wr_i && page_wdata_i == 10'h000 |=> $stable(data_read_page_reg_o);
  endproperty
  property p_page_load;
    page_wr_i && page_wdata_i != 10'h000 |=> data_read_page_reg_o == $past(page_wdata_i);
  endproperty
  property p_low; acc_w && !dacc_i.ea[15] |=>
    mem_req_o.valid && mem_req_o.addr == {9'h000, $past(dacc_i.ea)}; endproperty
  property p_paged; acc_w && dacc_i.ea[15] && !unp_w && !data_read_page_reg_o[9] |=>
    mem_req_o.addr == ({$past(data_read_page_reg_o), 15'h0000} | 25'($past(dacc_i.ea) & 16'h7FFF));
  endproperty
  property p_unpaged; acc_w && unp_w |=>
    mem_req_o.valid && mem_req_o.addr == {9'h000, $past(dacc_i.ea)}; endproperty
  property p_call; stk_req_i.call && stk_w |=>
    (mem_req_o.valid && mem_req_o.write && busy_o && mem_req_o.wdata == 16'($past(pc_i)))
    ##1 (mem_req_o.valid && !busy_o && mem_req_o.wdata[15:8] == 8'h00); endproperty
  property p_exc; stk_req_i.exc && !stk_req_i.call && stk_w |=>
    ##1 mem_req_o.wdata[15:8] == 8'($past(cpu_status_reg_i, 2)); endproperty
  property p_push; stk_req_i.push && !stk_req_i.call && !stk_req_i.exc && stk_w |=>
    mem_req_o.write && mem_req_o.addr == 25'($past(stack_pointer_word_o))
    && stack_pointer_word_o == $past(stack_pointer_word_o) + 16'h0002; endproperty
  property p_fetch; $past(resetn_i) |-> fetch_addr_o == ({1'b0, $past(pc_i)} & 24'h7FFFFE);
  endproperty
  property p_tbl; tbl_valid_i |=> tbl_req_o.valid && tbl_req_o.cfg == tbl_req_o.addr[23]
    && tbl_req_o.addr == {$past(table_page_reg_o), $past(tbl_ea_i)}; endproperty

  // ==========================================================================
  // assertions and covers
  a_sp_align: assert property (p_sp_align) else $error("stack pointer bit zero set");
  a_rst_vals: assert property (p_rst_vals) else $error("bad values after reset");
  a_page_keep: assert property (p_page_keep) else $error("page changed by zero");
  a_page_load: assert property (p_page_load) else $error("page write lost");
  a_low: assert property (p_low) else $error("low half address paged");
  a_paged: assert property (p_paged) else $error("paged address wrong");
  a_unpaged: assert property (p_unpaged) else $error("pointer access paged");
  a_call: assert property (p_call) else $error("call frame wrong");
  a_exc: assert property (p_exc) else $error("status byte not stacked");
  a_push: assert property (p_push) else $error("push order wrong");
  a_fetch: assert property (p_fetch) else $error("fetch address wrong");
  a_tbl: assert property (p_tbl) else $error("table address wrong");
  c_call: cover property (stk_req_i.call && stk_w);
  c_window: cover property (mem_req_o.valid && mem_req_o.prog);
  c_cfg: cover property (tbl_req_o.valid && tbl_req_o.cfg);
endmodule

bind dsa_addr_gen dsa_addr_gen_asserts chk_u (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
  .page_wr_i(page_wr_i), .page_wdata_i(page_wdata_i), .sp_wr_i(sp_wr_i), .pc_i(pc_i),
  .cpu_status_reg_i(cpu_status_reg_i), .frame_active_flag_i(frame_active_flag_i),
  .stk_req_i(stk_req_i), .dacc_i(dacc_i), .tbl_valid_i(tbl_valid_i), .tbl_ea_i(tbl_ea_i),
  .busy_o(busy_o), .dacc_ready_o(dacc_ready_o), .mem_req_o(mem_req_o),
  .tbl_req_o(tbl_req_o), .fetch_addr_o(fetch_addr_o),
  .stack_pointer_word_o(stack_pointer_word_o),
  .data_read_page_reg_o(data_read_page_reg_o), .table_page_reg_o(table_page_reg_o));
`default_nettype wire

// ---- dsa_addr_gen_test.sv ----
// testbench for the data space and stack addressing block
// assumes package, design, memory model and checker compiled before it
`timescale 1ns/1ns
`default_nettype none

module dsa_addr_gen_test;
  // ==========================================================================
  // signals
  logic                  clk_sys_i;
  logic                  resetn_i;
  logic                  page_wr_i;
  logic [9:0]            page_wdata_i;
  logic                  tpage_wr_i;
  logic [7:0]            tpage_wdata_i;
  logic                  sp_wr_i;
  logic [15:0]           sp_wdata_i;
  logic [22:0]           pc_i;
  logic [15:0]           sr_i;
  logic                  frame_i;
  dsa_pkg::dsa_stk_req_t stk_i;
  dsa_pkg::dsa_dacc_t    dacc_i;
  logic                  tbl_valid_i;
  logic                  tbl_write_i;
  logic                  tbl_byte_i;
  logic [15:0]           tbl_ea_i;
  logic                  busy_o;
  logic                  ready_o;
  dsa_pkg::dsa_mem_req_t mem_o;
  dsa_pkg::dsa_tbl_req_t tbl_o;
  logic [23:0]           fetch_o;
  logic                  err_o;
  logic [15:0]           sp_o;
  logic [9:0]            page_o;
  logic [7:0]            tpage_o;
  dsa_pkg::dsa_mem_req_t mq;  // outputs one cycle after a request
  dsa_pkg::dsa_tbl_req_t tq;
  logic                  bq;
  int                    errors;
  int                    total_checks;

  dsa_addr_gen dut_u (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .page_wr_i(page_wr_i),
    .page_wdata_i(page_wdata_i), .tpage_wr_i(tpage_wr_i), .tpage_wdata_i(tpage_wdata_i),
    .sp_wr_i(sp_wr_i), .sp_wdata_i(sp_wdata_i), .pc_i(pc_i), .cpu_status_reg_i(sr_i),
    .frame_active_flag_i(frame_i), .stk_req_i(stk_i), .dacc_i(dacc_i),
    .tbl_valid_i(tbl_valid_i), .tbl_write_i(tbl_write_i), .tbl_byte_i(tbl_byte_i),
    .tbl_ea_i(tbl_ea_i), .busy_o(busy_o), .dacc_ready_o(ready_o), .mem_req_o(mem_o),
    .tbl_req_o(tbl_o), .fetch_addr_o(fetch_o), .addr_error_o(err_o),
    .stack_pointer_word_o(sp_o), .data_read_page_reg_o(page_o), .table_page_reg_o(tpage_o));
  dsa_mem_model mem_u (.clk_sys_i(clk_sys_i), .mem_req_i(mem_o));

  // ==========================================================================
  // clock and tasks
  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic clr();
    page_wr_i = 1'b0;
    tpage_wr_i = 1'b0;
    sp_wr_i = 1'b0;
    stk_i = '0;
    dacc_i = '0;
    tbl_valid_i = 1'b0;
    tbl_write_i = 1'b0;
    tbl_byte_i = 1'b0;
  endtask

  // one request cycle, capture answer, then two idle cycles
  task automatic go();
    @(negedge clk_sys_i);
    mq = mem_o;
    tq = tbl_o;
    bq = busy_o;
    clr();
    @(negedge clk_sys_i);
    @(negedge clk_sys_i);
  endtask

  task automatic wpage(input logic [9:0] v);
    page_wr_i = 1'b1;
    page_wdata_i = v;
    go();
  endtask

  task automatic acc(input logic w, input logic s, input logic f, input logic [15:0] ea,
                     input logic [26:0] exp);
    dacc_i.valid = 1'b1;
    dacc_i.write = w;
    dacc_i.via_sp = s;
    dacc_i.via_fp = f;
    dacc_i.ea = ea;
    dacc_i.wdata = 16'h5A5A;
    go();
    chk(32'({mq.valid, mq.prog}), 32'(exp[26:25]));
    if (exp[26]) begin
      chk(32'(mq.addr), 32'(exp[24:0]));
    end
  endtask

  task automatic tbl(input logic [7:0] pg, input logic w, input logic b, input logic [15:0] ea);
    tpage_wr_i = 1'b1;
    tpage_wdata_i = pg;
    go();
    tbl_valid_i = 1'b1;
    tbl_write_i = w;
    tbl_byte_i = b;
    tbl_ea_i = ea;
    go();
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // tests
  initial begin
    errors = 0;
    total_checks = 0;
    resetn_i = 1'b0;
    page_wdata_i = 10'h000;
    tpage_wdata_i = 8'h00;
    sp_wdata_i = 16'h0000;
    tbl_ea_i = 16'h0000;
    pc_i = 23'h5A1235;
    sr_i = 16'h00C3;
    frame_i = 1'b0;
    clr();
    repeat (20) @(negedge clk_sys_i);
    resetn_i = 1'b1;
    chk(32'(sp_o), 32'h1000);
    chk(32'(page_o), 32'h001);
    wpage(10'h000);
    chk(32'(page_o), 32'h001);
    wpage(10'h003);
    acc(1'b0, 1'b0, 1'b0, 16'h1234, {2'b10, 25'h0001234});
    acc(1'b1, 1'b0, 1'b0, 16'h8010, {2'b10, 25'h0018010});
    acc(1'b0, 1'b1, 1'b0, 16'h8010, {2'b10, 25'h0008010});
    frame_i = 1'b1;
    acc(1'b0, 1'b0, 1'b1, 16'h9000, {2'b10, 25'h0009000});
    frame_i = 1'b0;
    acc(1'b0, 1'b0, 1'b1, 16'h9000, {2'b10, 25'h0019000});
    wpage(10'h201);
    acc(1'b0, 1'b0, 1'b0, 16'h8004, {2'b11, 25'h0008004});
    acc(1'b1, 1'b0, 1'b0, 16'h8004, 27'h0);
    chk(32'(err_o), 32'h0);
    sp_wr_i = 1'b1;
    sp_wdata_i = 16'h2003;
    go();
    chk(32'(sp_o), 32'h2002);
    stk_i.call = 1'b1;
    #1;
    chk(32'(ready_o), 32'h0);
    go();
    chk(32'(bq), 32'h1);
    chk(32'(mem_u.mem[25'h2002]), 32'h1235);
    chk(32'(mem_u.mem[25'h2004]), 32'h005A);
    stk_i.exc = 1'b1;
    go();
    chk(32'(mem_u.mem[25'h2008]), 32'hC35A);
    chk(32'(sp_o), 32'h200A);
    stk_i.push = 1'b1;
    stk_i.wdata = 16'hBEEF;
    go();
    chk(32'(mem_u.mem[25'h200A]), 32'hBEEF);
    stk_i.pop = 1'b1;
    go();
    chk(32'({mq.write, mq.addr}), 32'h200A);
    stk_i.ret = 1'b1;
    go();
    chk(32'({sp_o, mq.addr[15:0]}), 32'h2006_2008);
    chk(32'(fetch_o), 32'h5A1234);
    tbl(8'h80, 1'b0, 1'b1, 16'h0003);
    chk(32'(tq), {4'h0, 4'b1011, 24'h800003});
    tbl(8'h12, 1'b1, 1'b0, 16'hFFFF);
    chk(32'(tq), {4'h0, 4'b1100, 24'h12FFFF});
    chk(32'(tpage_o), 32'h12);
    chk(32'(mem_u.bad_writes), 32'h0);
    resetn_i = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    chk(32'({sp_o, 6'h00, page_o}), 32'h1000_0001);
    resetn_i = 1'b1;
    @(negedge clk_sys_i);
    give_verdict();
  end

  // watchdog against a hung sequence
  initial begin
    repeat (2000) @(posedge clk_sys_i);
    errors++;
    give_verdict();
  end
endmodule
`default_nettype wire

// ---- dsa_mem_model.sv ----
// data memory model behind the addressing block
// assumes requests arrive as one-cycle pulses on the core clock
`timescale 1ns/1ns
`default_nettype none

module dsa_mem_model (
  // clock
  input wire logic                  clk_sys_i,
  // request from the block
  input wire dsa_pkg::dsa_mem_req_t mem_req_i
);
  // ==========================================================================
  // storage of 16-bit words by byte address
  logic [15:0] mem [logic [24:0]];
  int          bad_writes;

  // keep writes, count any write into the program window
  initial bad_writes = 0;
  always @(posedge clk_sys_i) begin
    if (mem_req_i.valid && mem_req_i.write && mem_req_i.prog) begin
      bad_writes++;
    end else if (mem_req_i.valid && mem_req_i.write) begin
      mem[mem_req_i.addr] = mem_req_i.wdata;
    end
  end
endmodule
`default_nettype wire

// ---- dsa_page_reg.sv ----
// data read page register for the data space and stack addressing block
// assumes writes come from the core on the same clock
`timescale 1ns/1ns
`default_nettype none

module dsa_page_reg (
  // clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       resetn_i,
  // write port
  input  wire logic       wr_i,
  input  wire logic [9:0] wdata_i,
  // state
  output logic      [9:0] page_o,
  output logic            zero_o,
  output logic            prog_o
);

  logic [9:0] page_q;
  logic [9:0] page_d;
  logic       wr_take;

  // ==========================================================================
  // write decode
  // a zero value is dropped so the register never holds page zero
  assign wr_take = wr_i && (wdata_i != dsa_pkg::PAGE_ZERO);
  assign page_d  = wr_take ? wdata_i : page_q;

  // register, one after reset
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      page_q <= dsa_pkg::PAGE_RST;
    end else begin
      page_q <= page_d;
    end
  end

  // ==========================================================================
  // outputs
  assign page_o = page_q;
  assign zero_o = (page_q == dsa_pkg::PAGE_ZERO);
  assign prog_o = page_q[dsa_pkg::PAGE_PROG_BIT];

endmodule

`default_nettype wire

// ---- dsa_pkg.sv ----
// package for the data space and stack addressing block
// assumes one core clock and a core that holds each request for one cycle
package dsa_pkg;

  // ==========================================================================
  // widths
  localparam int DATA_W  = 16;  // data space word
  localparam int PROG_W  = 24;  // program space word and address
  localparam int PC_W    = 23;  // program counter
  localparam int PAGE_W  = 10;  // data read page register
  localparam int DADDR_W = 25;  // paged data address, page and low 15 ea bits
  localparam int TPAGE_W = 8;   // table page register

  // ==========================================================================
  // field positions
  localparam int EA_WIN_BIT    = 15;  // ea bit that opens the paged window
  localparam int PAGE_PROG_BIT = 9;   // page bit that maps the program window
  localparam int TBL_CFG_BIT   = 7;   // table page bit for configuration space
  localparam int SP_ALIGN_BIT  = 0;   // stack pointer bit tied to zero

  // ==========================================================================
  // values after reset and fixed codes
  localparam logic [9:0]  PAGE_RST     = 10'h001;
  localparam logic [9:0]  PAGE_ZERO    = 10'h000;
  localparam logic [7:0]  TPAGE_RST    = 8'h00;
  localparam logic [15:0] SP_RST       = 16'h1000;
  localparam logic [15:0] SP_STEP      = 16'h0002;  // one word in bytes
  localparam logic [7:0]  CALL_HI_FILL = 8'h00;
  localparam logic [8:0]  BASE_PAGE    = 9'h000;    // unpaged base range
  localparam logic [0:0]  PC_PAD       = 1'h0;

  // ==========================================================================
  // stack sequencer states
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b001,
    ST_PUSH_HI = 3'b010,
    ST_POP_LO  = 3'b100
  } dsa_stk_st_t;

  // ==========================================================================
  // carriers
  // data access from the core
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        via_sp;  // ea taken from the stack pointer word
    logic        via_fp;  // ea taken from the frame pointer word
    logic [15:0] ea;
    logic [15:0] wdata;
  } dsa_dacc_t;

  // stack requests from the core
  typedef struct packed {
    logic        push;
    logic        pop;
    logic        call;
    logic        exc;
    logic        ret;
    logic [15:0] wdata;
  } dsa_stk_req_t;

  // request towards data memory
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        prog;    // program window, low word of a program word
    logic [24:0] addr;
    logic [15:0] wdata;
  } dsa_mem_req_t;

  // table request towards program memory
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        byte_op;
    logic        cfg;
    logic [23:0] addr;
  } dsa_tbl_req_t;

endpackage
